// ==== verilog/scb_link_ctrl.sv ====
// card-side block link controller: error recovery, chaining and supervisory exchanges
`timescale 1ns/1ps
`include "scb_cfg.svh"
module scb_link_ctrl (
  input  wire logic       clk_sys,        // system clock
  input  wire logic       arst_n,         // async reset, active low
  input  wire logic [3:0] regAddr,        // register address
  input  wire logic [7:0] regWdata,       // register write data
  input  wire logic       regWrite,       // write strobe
  input  wire logic       regRead,        // read strobe
  output logic      [7:0] regRdata,       // read data, cycle after strobe
  input  wire logic       rxBlock,        // framer: block received pulse
  input  wire logic [7:0] rxPcb,          // received protocol_control_byte
  input  wire logic [7:0] rxLen,          // received info_length_byte
  input  wire logic [7:0] rxInf,          // first information byte
  input  wire logic       rxParityErr,    // parity error seen in block
  input  wire logic       rxEdcErr,       // error_detect_code mismatch
  input  wire logic       rxSyncLost,     // character framing lost
  input  wire logic       txDone,         // framer: last character sent
  input  wire logic       appSend,        // send one I-block pulse
  input  wire logic [7:0] appSendLen,     // its information length
  input  wire logic       appSendMore,    // more-data bit for it
  input  wire logic       appIfsReq,      // offer card size pulse
  input  wire logic [7:0] appIfsValue,    // offered size
  input  wire logic       appAbortReq,    // abort chain pulse
  output logic            txStart,        // framer: send block pulse
  output logic      [7:0] txPcb,          // control byte to send
  output logic      [7:0] txLen,          // length to send
  output logic      [7:0] txInf,          // single info byte for S-blocks
  output logic            rxDeliver,      // I-block accepted pulse
  output logic            rxDeliverMore,  // accepted block is chained
  output logic            txAck,          // chained piece acknowledged pulse
  output logic            chainAborted,   // chain abortion done pulse
  output logic            sendRefused     // I-block too long pulse
);
  scb_pkg::scb_state_e state, next_state;
  scb_pkg::scb_kind_e  lastKind, next_kind;
  logic [1:0] retry, next_retry;
  logic       ifsTry, next_ifsTry;
  logic       firstBlock, next_first;
  logic       ns, next_ns, nr, next_nr;
  logic       hasTurn, next_turn;
  logic       txMore, next_txMore;
  logic [7:0] termIfs, next_termIfs;
  logic [7:0] cardIfs;
  logic       enable, startPulse;
  logic       sendNow, doResync, deliver, deliverMore, ack, abortEvt, refused;
  logic [7:0] sendPcb, sendLen, sendInf;
  scb_pkg::scb_kind_e sendKind;

  function automatic logic [7:0] rBlock(input logic seq, input logic [3:0] code);
    rBlock = `SCB_PCB_R | {3'h0, seq, code};
  endfunction : rBlock

  // receive classification
  logic       isI, isR, isS, isSReq;
  logic [4:0] sType;
  logic       badPcb, badLen, missResp, invalid, overIfs, parityLike;
  logic [3:0] errCode;
  assign isI      = ~rxPcb[7];
  assign isR      = rxPcb[7:6] == 2'b10;
  assign isS      = rxPcb[7:6] == 2'b11;
  assign isSReq   = isS & ~rxPcb[5];
  assign sType    = rxPcb[4:0];
  assign badPcb   = (isI & (rxPcb[4:0] != 5'h00))
                  | (isR & (rxPcb[5] | (rxPcb[3:0] > `SCB_RCODE_OTHER)))
                  | (isS & (sType > `SCB_S_ABORT));
  assign badLen   = (rxLen == `SCB_LEN_RFU)
                  | (isR & (rxLen != 8'h00))
                  | (isS & (sType == `SCB_S_IFS) & (rxLen != 8'h01))
                  | (isS & (sType != `SCB_S_IFS) & (rxLen != 8'h00));
  assign missResp = (lastKind == scb_pkg::SCB_K_SREQ) & ~(isS & rxPcb[5]);
  assign parityLike = rxParityErr | rxEdcErr;
  assign invalid  = parityLike | rxSyncLost | badPcb | badLen | missResp;
  // a terminal chain piece of any length up to the card size is taken
  assign overIfs  = isI & (rxLen > cardIfs);
  assign errCode  = parityLike ? `SCB_RCODE_EDC : `SCB_RCODE_OTHER;

  always_comb begin
    next_state   = state;
    next_kind    = lastKind;
    next_retry   = retry;
    next_ifsTry  = ifsTry;
    next_first   = firstBlock;
    next_ns      = ns;
    next_nr      = nr;
    next_turn    = hasTurn;
    next_txMore  = txMore;
    next_termIfs = termIfs;
    sendNow      = 1'b0;
    doResync     = 1'b0;
    sendPcb      = txPcb;
    sendLen      = txLen;
    sendInf      = txInf;
    sendKind     = lastKind;
    deliver      = 1'b0;
    deliverMore  = 1'b0;
    ack          = 1'b0;
    abortEvt     = 1'b0;
    refused      = 1'b0;
    if (startPulse) begin
      next_state  = scb_pkg::SCB_RX;
      next_kind   = scb_pkg::SCB_K_NONE;
      next_retry  = 2'h0;
      next_ifsTry = 1'b0;
      next_first  = 1'b1;
      next_ns     = 1'b0;
      next_nr     = 1'b0;
      next_turn   = 1'b0;
      next_txMore = 1'b0;
    end else if (enable) begin
      unique case (state)
        scb_pkg::SCB_TX: begin
          if (txDone) begin
            next_state = scb_pkg::SCB_RX;
            next_turn  = 1'b0;
          end
        end
        scb_pkg::SCB_MUTE: begin
          // besides a protocol start, only a clean resynchronisation request wakes a silent card
          if (rxBlock && !invalid && isSReq && sType == `SCB_S_RESYNC) begin
            doResync = 1'b1;
          end
        end
        scb_pkg::SCB_RX: begin
          if (rxBlock) begin
            if (invalid || overIfs) begin
              if (retry == `SCB_RETRY_MAX) begin
                next_state = scb_pkg::SCB_MUTE;
              end else begin
                next_retry = retry + 2'h1;
                if (firstBlock) begin
                  sendNow  = 1'b1;
                  sendPcb  = rBlock(1'b0, overIfs && !invalid ? `SCB_RCODE_OTHER : errCode);
                  sendLen  = 8'h00;
                  sendKind = scb_pkg::SCB_K_R;
                end else if (!invalid) begin
                  sendNow  = 1'b1;
                  sendPcb  = rBlock(nr, `SCB_RCODE_OTHER);
                  sendLen  = 8'h00;
                  sendKind = scb_pkg::SCB_K_R;
                end else if (lastKind == scb_pkg::SCB_K_SREQ) begin
                  if (!ifsTry) begin
                    next_ifsTry = 1'b1;
                    sendNow     = 1'b1;
                  end else begin
                    next_kind = scb_pkg::SCB_K_NONE;
                  end
                end else if (lastKind == scb_pkg::SCB_K_R) begin
                  sendNow = 1'b1;
                end else begin
                  sendNow  = 1'b1;
                  sendPcb  = rBlock(nr, errCode);
                  sendLen  = 8'h00;
                  sendKind = scb_pkg::SCB_K_R;
                end
              end
            end else begin
              next_retry  = 2'h0;
              next_ifsTry = 1'b0;
              next_first  = 1'b0;
              if (isI) begin
                if (rxPcb[6] == nr) begin
                  next_nr     = ~nr;
                  deliver     = 1'b1;
                  deliverMore = rxPcb[5];
                  if (rxPcb[5]) begin
                    sendNow  = 1'b1;
                    sendPcb  = rBlock(~nr, `SCB_RCODE_OK);
                    sendLen  = 8'h00;
                    sendKind = scb_pkg::SCB_K_R;
                  end else begin
                    next_turn = 1'b1;
                    next_kind = scb_pkg::SCB_K_NONE;
                  end
                end else begin
                  sendNow  = 1'b1;
                  sendPcb  = rBlock(nr, `SCB_RCODE_OK);
                  sendLen  = 8'h00;
                  sendKind = scb_pkg::SCB_K_R;
                end
              end else if (isR) begin
                if (lastKind == scb_pkg::SCB_K_I && rxPcb[4] != txPcb[6] && txMore) begin
                  ack       = 1'b1;
                  next_turn = 1'b1;
                  next_kind = scb_pkg::SCB_K_NONE;
                end else if (lastKind == scb_pkg::SCB_K_SRESP || lastKind == scb_pkg::SCB_K_NONE) begin
                  next_turn = 1'b1;
                end else begin
                  sendNow = 1'b1;
                end
              end else if (isSReq) begin
                if (sType == `SCB_S_RESYNC) begin
                  doResync = 1'b1;
                end else begin
                  sendNow  = 1'b1;
                  sendPcb  = `SCB_PCB_S_RESP | {3'h0, sType};
                  sendLen  = rxLen;
                  sendInf  = rxInf;
                  sendKind = scb_pkg::SCB_K_SRESP;
                  if (sType == `SCB_S_IFS) begin
                    next_termIfs = rxInf;
                  end else begin
                    abortEvt    = 1'b1;
                    next_txMore = 1'b0;
                  end
                end
              end else if (sType == txPcb[4:0] && lastKind == scb_pkg::SCB_K_SREQ) begin
                next_kind = scb_pkg::SCB_K_NONE;
                next_turn = 1'b1;
                if (sType == `SCB_S_ABORT) begin
                  abortEvt    = 1'b1;
                  next_txMore = 1'b0;
                end
              end else begin
                sendNow = 1'b1;
              end
            end
          end else if (hasTurn) begin
            if (appSend) begin
              if (appSendLen > termIfs) begin
                refused = 1'b1;
              end else begin
                // empty blocks are legal but wasteful; the application is trusted to avoid them
                sendNow     = 1'b1;
                sendPcb     = {1'b0, ns, appSendMore, 5'h00};
                sendLen     = appSendLen;
                sendKind    = scb_pkg::SCB_K_I;
                next_ns     = ~ns;
                next_txMore = appSendMore;
              end
            end else if (appIfsReq) begin
              sendNow  = 1'b1;
              sendPcb  = `SCB_PCB_S_REQ | {3'h0, `SCB_S_IFS};
              sendLen  = 8'h01;
              sendInf  = appIfsValue;
              sendKind = scb_pkg::SCB_K_SREQ;
            end else if (appAbortReq) begin
              sendNow  = 1'b1;
              sendPcb  = `SCB_PCB_S_REQ | {3'h0, `SCB_S_ABORT};
              sendLen  = 8'h00;
              sendKind = scb_pkg::SCB_K_SREQ;
            end
          end
        end
      endcase
      if (doResync) begin
        next_ns     = 1'b0;
        next_nr     = 1'b0;
        next_txMore = 1'b0;
        next_retry  = 2'h0;
        next_kind   = scb_pkg::SCB_K_SRESP;
        sendNow     = 1'b1;
        sendPcb     = `SCB_PCB_S_RESP | {3'h0, `SCB_S_RESYNC};
        sendLen     = 8'h00;
        sendKind    = scb_pkg::SCB_K_SRESP;
      end
      if (sendNow) begin
        next_state = scb_pkg::SCB_TX;
        next_kind  = sendKind;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state      <= scb_pkg::SCB_RX;
      lastKind   <= scb_pkg::SCB_K_NONE;
      retry      <= 2'h0;
      ifsTry     <= 1'b0;
      firstBlock <= 1'b1;
      ns         <= 1'b0;
      nr         <= 1'b0;
      hasTurn    <= 1'b0;
      txMore     <= 1'b0;
      termIfs    <= `SCB_TERM_IFS_RST;
    end else begin
      state      <= next_state;
      lastKind   <= next_kind;
      retry      <= next_retry;
      ifsTry     <= next_ifsTry;
      firstBlock <= next_first;
      ns         <= next_ns;
      nr         <= next_nr;
      hasTurn    <= next_turn;
      txMore     <= next_txMore;
      termIfs    <= next_termIfs;
    end
  end

  // block fields are held after the start pulse so retransmission replays them
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      txStart <= 1'b0;
      txPcb   <= 8'h00;
      txLen   <= 8'h00;
      txInf   <= 8'h00;
    end else begin
      txStart <= sendNow;
      txPcb   <= sendPcb;
      txLen   <= sendLen;
      txInf   <= sendInf;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rxDeliver     <= 1'b0;
      rxDeliverMore <= 1'b0;
      txAck         <= 1'b0;
      chainAborted  <= 1'b0;
      sendRefused   <= 1'b0;
    end else begin
      rxDeliver     <= deliver;
      rxDeliverMore <= deliverMore;
      txAck         <= ack;
      chainAborted  <= abortEvt;
      sendRefused   <= refused;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      enable     <= `SCB_CTRL_RST;
      startPulse <= 1'b0;
      cardIfs    <= `SCB_CARD_IFS_RST;
    end else begin
      startPulse <= regWrite && regAddr == `SCB_REG_CTRL && regWdata[`SCB_CTRL_START_BIT];
      if (regWrite && regAddr == `SCB_REG_CTRL) begin
        enable <= regWdata[`SCB_CTRL_EN_BIT];
      end
      if (regWrite && regAddr == `SCB_REG_CARD_IFS) begin
        cardIfs <= regWdata;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      unique case (regAddr)
        `SCB_REG_CTRL:     regRdata <= {7'h00, enable};
        `SCB_REG_CARD_IFS: regRdata <= cardIfs;
        `SCB_REG_TERM_IFS: regRdata <= termIfs;
        `SCB_REG_STATUS:   regRdata <= {state == scb_pkg::SCB_MUTE, hasTurn, ns, nr, retry,
                                        firstBlock, state == scb_pkg::SCB_TX};
        default:           regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

  logic rxLive;
  assign rxLive = enable && !startPulse && state == scb_pkg::SCB_RX && rxBlock;

  first_invalid_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rxLive && invalid && retry != `SCB_RETRY_MAX && firstBlock |=> txStart && txPcb[7:4] == 4'h8 && txLen == 8'h00)
    else $error("invalid first block not answered with R(0)");
  mute_escalate_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rxLive && (invalid || overIfs) && retry == `SCB_RETRY_MAX |=> state == scb_pkg::SCB_MUTE && !txStart)
    else $error("card did not fall silent after repeated failures");
  r_repeat_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rxLive && invalid && retry != `SCB_RETRY_MAX && !firstBlock && lastKind == scb_pkg::SCB_K_R
    |=> txStart && txPcb == $past(txPcb) && txLen == $past(txLen))
    else $error("R-block not repeated");
  i_nack_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rxLive && invalid && retry != `SCB_RETRY_MAX && !firstBlock && lastKind == scb_pkg::SCB_K_I
    |=> txStart && txPcb[7:5] == 3'b100 && txPcb[4] == $past(nr) && txPcb[3:0] != 4'h0)
    else $error("I-block failure not answered by R-block of awaited sequence");
  chain_ack_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rxLive && !invalid && !overIfs && isI && rxPcb[6] == nr && rxPcb[5] |=> txStart && rxDeliver && txPcb == {3'b100, ~$past(nr), 4'h0})
    else $error("chained I-block not acknowledged with next sequence");
  over_size_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rxLive && !invalid && overIfs && retry != `SCB_RETRY_MAX |=> txStart && txPcb[7:5] == 3'b100 && txPcb[3:0] == 4'h2)
    else $error("oversize block not rejected with code 2");
  send_limit_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    enable && !startPulse && state == scb_pkg::SCB_RX && !rxBlock && hasTurn && appSend && appSendLen > termIfs
    |=> sendRefused && !txStart ##1 !sendRefused)
    else $error("oversize card I-block not refused");
  turn_pass_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    enable && !startPulse && state == scb_pkg::SCB_TX && txDone |=> state == scb_pkg::SCB_RX && !hasTurn)
    else $error("turn not passed after transmission");
  retry_clear_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rxLive && !invalid && !overIfs |=> retry == 2'h0 && !ifsTry)
    else $error("retry count not cleared on good block");
  abort_answer_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rxLive && !invalid && isSReq && sType == `SCB_S_ABORT |=> txStart && chainAborted && txPcb == 8'he2)
    else $error("abort request not answered");
  ifs_giveup_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rxLive && invalid && retry != `SCB_RETRY_MAX && !firstBlock && lastKind == scb_pkg::SCB_K_SREQ && ifsTry
    |=> !txStart && state == scb_pkg::SCB_RX)
    else $error("size request repeated more than once");
endmodule : scb_link_ctrl

// ==== common/scb_cfg.svh ====
// offsets, field positions, reset values and limits of the card-side block link controller
// Function
// - Invalid: parity, check code, bad control byte, bad length, lost sync, missing response.
// - Card escalates: retransmit, answer resynchronisation, otherwise become unresponsive.
// - Card answers an invalid first block after protocol start with R(0).
// - After an I-block, error or time-out draws R-block naming awaited sequence.
// - After an R-block, error or time-out repeats that same R-block.
// - After supervisory request, time-out or non-response reply repeats the request.
// - After supervisory response, error or time-out draws an R-block.
// - Card repeats failed size request once, then stays in reception.
// - More-data bit set chains next I-block; cleared ends the chain.
// - More-data I-block is answered with R-block naming next awaited sequence.
// - Abort request answered by abort response; R-block may return the turn.
// - Card chain blocks never exceed the terminal information field size.
// - Block longer than card size rejected with R-block error code 2.
// - Senders should avoid empty I-blocks.
// - R-block low nibble: 0 error free, 1 check/parity, 2 other.
// - Type from top bits: 0x I-block, 10 R-block, 11 supervisory.
`ifndef SCB_CFG_SVH
`define SCB_CFG_SVH
`define SCB_REG_CTRL       4'h0
`define SCB_REG_CARD_IFS   4'h1
`define SCB_REG_TERM_IFS   4'h2
`define SCB_REG_STATUS     4'h3
`define SCB_CTRL_EN_BIT    0
`define SCB_CTRL_START_BIT 1
`define SCB_CTRL_RST       1'h0
`define SCB_CARD_IFS_RST   8'h20
`define SCB_TERM_IFS_RST   8'h20
`define SCB_RETRY_MAX      2'h2
`define SCB_PCB_R          8'h80
`define SCB_PCB_S_REQ      8'hc0
`define SCB_PCB_S_RESP     8'he0
`define SCB_S_RESYNC       5'h00
`define SCB_S_IFS          5'h01
`define SCB_S_ABORT        5'h02
`define SCB_RCODE_OK       4'h0
`define SCB_RCODE_EDC      4'h1
`define SCB_RCODE_OTHER    4'h2
`define SCB_LEN_RFU        8'hff
`endif

// ==== common/scb_pkg.sv ====
// types of the card-side block link controller
package scb_pkg;
  typedef enum logic [1:0] {SCB_RX, SCB_TX, SCB_MUTE} scb_state_e;
  typedef enum logic [2:0] {SCB_K_NONE, SCB_K_I, SCB_K_R, SCB_K_SREQ, SCB_K_SRESP} scb_kind_e;
endpackage : scb_pkg

// ==== dv/scb_term_model.sv ====
// terminal-side framer model: sends each block the card starts, then hands the turn back
`timescale 1ns/1ps
module scb_term_model (
  input  wire logic clk_sys,  // system clock
  input  wire logic arst_n,   // async reset, active low
  input  wire logic txStart,  // card starts a block
  input  wire logic slow,     // long character time
  output logic      txDone,   // last character sent
  output logic      busy      // block on the wire
);
  logic [3:0] cnt;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt    <= 4'h0;
      busy   <= 1'b0;
      txDone <= 1'b0;
    end else begin
      // done pulse closes the block, the turn passes to the terminal
      txDone <= busy && (cnt == 4'h1);
      busy   <= txStart || (busy && (cnt != 4'h1));
      cnt    <= txStart ? (slow ? 4'h9 : 4'h3) : ((cnt != 4'h0) ? cnt - 4'h1 : cnt);
    end
  end
endmodule : scb_term_model

// ==== dv/tb.sv ====
// self-checking bench of the card-side block link controller
`timescale 1ns/1ps
module tb;
  logic       clk_sys = 1'b0, arst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, rxBlock = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00, regRdata, rxPcb = 8'h00, rxLen = 8'h00, rxInf = 8'h00, txPcb, txLen, txInf;
  logic       rxParityErr = 1'b0, rxEdcErr = 1'b0, rxSyncLost = 1'b0, txDone, busy, slow = 1'b0;
  logic       appSend = 1'b0, appSendMore = 1'b0, appIfsReq = 1'b0, appAbortReq = 1'b0;
  logic [7:0] appSendLen = 8'h00, appIfsValue = 8'h00;
  logic       txStart, rxDeliver, rxDeliverMore, txAck, chainAborted, sendRefused;
  logic       st, dv, mo, ak, ab, rf;
  logic [7:0] pc;
  int         fails = 0, num_checks = 0, cyc = 0;
  always #20 clk_sys = ~clk_sys;
  scb_link_ctrl u_scb_link_ctrl (.clk_sys(clk_sys), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .rxBlock(rxBlock), .rxPcb(rxPcb),
    .rxLen(rxLen), .rxInf(rxInf), .rxParityErr(rxParityErr), .rxEdcErr(rxEdcErr), .rxSyncLost(rxSyncLost),
    .txDone(txDone), .appSend(appSend), .appSendLen(appSendLen), .appSendMore(appSendMore),
    .appIfsReq(appIfsReq), .appIfsValue(appIfsValue), .appAbortReq(appAbortReq), .txStart(txStart),
    .txPcb(txPcb), .txLen(txLen), .txInf(txInf), .rxDeliver(rxDeliver), .rxDeliverMore(rxDeliverMore),
    .txAck(txAck), .chainAborted(chainAborted), .sendRefused(sendRefused));
  scb_term_model u_scb_term_model (.clk_sys(clk_sys), .arst_n(arst_n), .txStart(txStart), .slow(slow),
    .txDone(txDone), .busy(busy));
  task automatic conclude;
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 chk("regRdata", regRdata & m, exp);
  endtask : rd
  // released pcb and length lines are inverted on each grab, so an app after blk shows the last block's pcb and length inverted
  task automatic grab;
    int n;
    @(posedge clk_sys);
    {rxBlock, appSend, appIfsReq, appAbortReq, rxParityErr, rxEdcErr, rxSyncLost} <= 7'h00;
    rxPcb <= ~rxPcb;
    rxLen <= ~rxLen;
    #1 {st, pc, dv, mo, ak, ab, rf} = {txStart, txPcb, rxDeliver, rxDeliverMore, txAck, chainAborted, sendRefused};
    // busy is looked at after the edge has settled, so the turn is really back before the next block
    for (n = 0; n < 40 && (st === 1'b1) && (busy !== 1'b0 || n == 0); n++) @(posedge clk_sys) #1;
    repeat (2) @(posedge clk_sys);
  endtask : grab
  task automatic blk(input logic [7:0] p, input logic [7:0] l, input logic [2:0] e);
    @(posedge clk_sys);
    rxBlock <= 1'b1;
    rxPcb   <= p;
    rxLen   <= l;
    rxInf   <= l;
    {rxSyncLost, rxEdcErr, rxParityErr} <= e;
    grab();
  endtask : blk
  task automatic app(input logic s, input logic [7:0] l, input logic m);
    @(posedge clk_sys);
    appSend     <= s;
    appIfsReq   <= !s && !m;
    appAbortReq <= !s && m;
    appSendLen  <= l;
    appSendMore <= m;
    appIfsValue <= l;
    grab();
  endtask : app
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(4'h1, 8'hff, 8'h20);
    rd(4'h2, 8'hff, 8'h20);
    rd(4'h9, 8'hff, 8'h00);
    wr(4'h0, 8'h03);
    blk(8'h20, 8'h20, 3'h2); chk("first R", {st, pc[6:0]}, 8'h81);
    blk(8'h20, 8'h20, 3'h0); chk("chain ack", {st, pc[6:0]}, 8'h90);
    chk("deliver", {dv, mo}, 8'h03);
    blk(8'h60, 8'h21, 3'h0); chk("oversize", {st, pc[6:0]}, 8'h92);
    blk(8'h40, 8'h05, 3'h4); chk("same R", {st, pc[6:0]}, 8'h92);
    blk(8'h40, 8'h05, 3'h0); chk("last piece", {st, dv, mo}, 8'h02);
    app(1'b1, 8'h21, 1'b1); chk("refused", {st, rf}, 8'h01);
    slow <= 1'b1;
    app(1'b1, 8'h20, 1'b1); chk("card I", {st, pc[6:0]}, 8'ha0);
    blk(8'h90, 8'h00, 3'h0); chk("ack", {st, ak}, 8'h01);
    app(1'b1, 8'h03, 1'b0); chk("card I2", {st, pc[6:0]}, 8'hc0);
    blk(8'h40, 8'h00, 3'h1); chk("R after I", {st, pc[6:0]}, 8'h81);
    blk(8'h40, 8'h00, 3'h1); chk("R again", {st, pc[6:0]}, 8'h81);
    blk(8'h40, 8'h00, 3'h1); chk("mute", {7'h00, st}, 8'h00);
    rd(4'h3, 8'h80, 8'h80);
    blk(8'hc0, 8'h00, 3'h0); chk("resync", {st, pc[6:0]}, 8'he0);
    blk(8'hc2, 8'h00, 3'h0); chk("abort", {st, pc[6:0]}, 8'he2);
    chk("aborted", {7'h00, ab}, 8'h01);
    blk(8'h80, 8'h00, 3'h0); chk("turn back", {7'h00, st}, 8'h00);
    app(1'b0, 8'h00, 1'b1); chk("card abort", {st, pc[6:0]}, 8'hc2);
    blk(8'he2, 8'h00, 3'h0); chk("abort done", {st, ab}, 8'h01);
    app(1'b0, 8'h40, 1'b0); chk("size req", {st, pc[6:0]}, 8'hc1);
    blk(8'he1, 8'h01, 3'h2); chk("size again", {st, pc[6:0]}, 8'hc1);
    blk(8'he1, 8'h01, 3'h2); chk("size quiet", {7'h00, st}, 8'h00);
    wr(4'h0, 8'h03);
    blk(8'h80, 8'h00, 3'h0); chk("R0 wait", {7'h00, st}, 8'h00);
    rd(4'h3, 8'h42, 8'h40);
    conclude();
  end
endmodule : tb
